// ---- dmrt_byte_cnt.v ----
// One byte of the timer count with software write, increment and reload on wrap.
`timescale 1ns/100ps
`include "dmrt_consts.vh"
module dmrt_byte_cnt (
  input wire i_clock, // System clock.
  input wire i_arst_n, // Asynchronous reset, active low.
  input wire i_wr, // Software writes the count.
  input wire [7:0] i_wdata, // Value written by software.
  input wire i_inc, // Count enable for this cycle.
  input wire i_reload, // On wrap, load i_rl_val instead of zero.
  input wire [7:0] i_rl_val, // Reload value.
  output reg [7:0] o_count, // Current count.
  output wire o_wrap // High when this increment leaves 0xFF, to 0x00 or to i_rl_val.
);
  // Wrap depends only on enable and count, never on reload, to avoid a loop.
  assign o_wrap = i_inc & (o_count == 8'hFF);

  // A software write beats a same-cycle increment so software always sees its value.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count <= `DMRT_CNT_RST;
    end else if (i_wr) begin
      o_count <= i_wdata;
    end else if (i_inc) begin
      if (o_wrap) begin
        o_count <= i_reload ? i_rl_val : 8'h00;
      end else begin
        o_count <= o_count + 8'h01;
      end
    end
  end
endmodule

// ---- dmrt_consts.vh ----
// Register map, field positions, reset values and divider counts of the reload timer.
`ifndef DMRT_CONSTS_VH
`define DMRT_CONSTS_VH
// Register addresses on the byte-wide register port.
`define DMRT_ADDR_CTRL 8'hC8
`define DMRT_ADDR_RLL 8'hCA
`define DMRT_ADDR_RLH 8'hCB
`define DMRT_ADDR_CNTL 8'hCC
`define DMRT_ADDR_CNTH 8'hCD
`define DMRT_ADDR_CKSEL 8'hD0
`define DMRT_ADDR_ISTS 8'hD1
`define DMRT_ADDR_IMSK 8'hD2
// Field positions in timer_control.
`define DMRT_CTRL_HFLAG 7
`define DMRT_CTRL_LFLAG 6
`define DMRT_CTRL_LBEN 5
`define DMRT_CTRL_CAPEN 4
`define DMRT_CTRL_SPLIT 3
`define DMRT_CTRL_RUN 2
`define DMRT_CTRL_XCLK 0
// Field positions in the clock select and global enable register.
`define DMRT_CKSEL_LSEL 0
`define DMRT_CKSEL_HSEL 1
`define DMRT_CKSEL_GIE 2
// Field positions in the interrupt status and mask registers.
`define DMRT_INT_HOVF 0
`define DMRT_INT_LOVF 1
`define DMRT_INT_CAP 2
// Reset values.
`define DMRT_CTRL_RST 8'h00
`define DMRT_RL_RST 8'h00
`define DMRT_CNT_RST 8'h00
`define DMRT_CKSEL_RST 3'h0
`define DMRT_INT_RST 3'h0
// Clock dividers: system clock by 12, external oscillator by 8.
`define DMRT_SYS_DIV 4'hC
`define DMRT_EXT_DIV 4'h8
`endif

// ---- dmrt_tick_gen.v ----
// Count-enable generator: system clock divided by 12 and external oscillator divided by 8.
`timescale 1ns/100ps
`include "dmrt_consts.vh"
module dmrt_tick_gen #(
  parameter [3:0] SYS_DIV = `DMRT_SYS_DIV,
  parameter [3:0] EXT_DIV = `DMRT_EXT_DIV
) (
  input wire i_clock, // System clock.
  input wire i_arst_n, // Asynchronous reset, active low.
  input wire i_ext_osc, // External oscillator pin, asynchronous.
  output reg o_sys_tick, // One-cycle pulse every SYS_DIV clocks.
  output reg o_ext_tick // One-cycle pulse every EXT_DIV oscillator edges.
);
  reg [3:0] sys_cnt_ff; // Prescaler for the system clock.
  reg [3:0] ext_cnt_ff; // Counter of synchronised oscillator edges.
  reg ext_s1_ff; // First synchroniser stage.
  reg ext_s2_ff; // Second synchroniser stage.
  reg ext_s3_ff; // Delayed copy for edge detection.
  wire ext_rise = ext_s2_ff & ~ext_s3_ff; // Synchronised rising edge.

  // The oscillator is resynchronised, so it must run well below half the system clock.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_cnt_ff <= 4'h0;
      ext_cnt_ff <= 4'h0;
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      o_sys_tick <= 1'b0;
      o_ext_tick <= 1'b0;
    end else begin
      ext_s1_ff <= i_ext_osc;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      o_sys_tick <= (sys_cnt_ff == SYS_DIV - 4'h1);
      sys_cnt_ff <= (sys_cnt_ff == SYS_DIV - 4'h1) ? 4'h0 : sys_cnt_ff + 4'h1;
      o_ext_tick <= ext_rise & (ext_cnt_ff == EXT_DIV - 4'h1);
      if (ext_rise) begin
        ext_cnt_ff <= (ext_cnt_ff == EXT_DIV - 4'h1) ? 4'h0 : ext_cnt_ff + 4'h1;
      end
    end
  end
endmodule

// ---- dmrt_timer.v ----
// Dual-mode reload timer: one 16-bit or two 8-bit auto-reload counters with flags.
// Contract
// - Low byte rollover sets low overflow flag.
// - Low flag interrupts only when both enables set.
// - Low flag set in both modes.
// - Low flag stays until software clears it.
// - Low interrupt enable zero suppresses low interrupts.
// - Split bit selects 16-bit or two 8-bit.
// - Run bit gates whole counter, split: high only.
// - Split mode low byte always counts.
// - 16-bit wrap reloads and sets high flag.
// - Per-byte select: system_clock, system_clock/12 or ext/8; the choice of /12 or ext/8 is one bit shared by both bytes.
// - Split bytes reload from own reload byte.
// - Hardware never clears either overflow flag.
`timescale 1ns/100ps
`include "dmrt_consts.vh"
module dmrt_timer #(
  parameter [3:0] SYS_DIV = `DMRT_SYS_DIV,
  parameter [3:0] EXT_DIV = `DMRT_EXT_DIV
) (
  input wire i_clock, // System clock, 25 MHz.
  input wire i_arst_n, // Asynchronous reset, active low.
  input wire [7:0] i_addr, // Register address.
  input wire [7:0] i_wdata, // Register write data.
  input wire i_wr, // Write strobe, one cycle.
  input wire i_rd, // Read strobe, one cycle.
  output reg [7:0] o_rdata, // Read data, valid the cycle after i_rd.
  input wire i_ext_osc, // External oscillator pin.
  input wire i_lfo, // Low-frequency oscillator output pin.
  output wire o_irq // Level interrupt request, active high.
);

  // Reset images of the byte-wide registers. Fields are picked out by position,
  // so a change of reset value needs an edit of the shared header only.
  localparam [7:0] CTRL_RST = `DMRT_CTRL_RST; // Reset image of timer_control.
  localparam [2:0] CKSEL_RST = `DMRT_CKSEL_RST; // Reset image of the clock select register.

  // Picks the count enable of one byte from its select bit and the external select.
  // The fast select overrides the external select, so the external select only
  // matters for a byte that is not running at the full system clock rate.
  function sel_tick;
    input fast_sel;
    input ext_sel;
    input sys_tick;
    input ext_tick;
    begin
      if (fast_sel) begin
        sel_tick = 1'b1;
      end else if (ext_sel) begin
        sel_tick = ext_tick;
      end else begin
        sel_tick = sys_tick;
      end
    end
  endfunction

  // Software-visible state.
  reg high_overflow_flag_ff; // High byte or full overflow flag.
  reg low_overflow_flag_ff; // Low byte overflow flag.
  reg low_byte_irq_enable_ff; // Low byte interrupt enable.
  reg lfo_capture_enable_ff; // Oscillator capture enable.
  reg split_mode_select_ff; // 1 selects two 8-bit counters.
  reg run_control_ff; // Run control.
  reg external_clock_select_ff; // 1 selects external oscillator by 8.
  reg [7:0] reload_low_byte_ff; // Low reload byte.
  reg [7:0] reload_high_byte_ff; // High reload byte.
  reg low_byte_clock_select_ff; // 1 runs the low byte on the system clock.
  reg high_byte_clock_select_ff; // 1 runs the high byte on the system clock.
  reg timer_irq_enable_ff; // Global timer interrupt enable.
  reg [2:0] irq_status_ff; // Sticky interrupt events, write one to clear.
  reg [2:0] irq_mask_ff; // Interrupt mask, 1 passes the event.

  // Next values, built by the combinational processes below.
  // Keeping them apart from the flip-flops lets every priority be read in one place.
  reg nxt_high_overflow_flag; // Next high overflow flag.
  reg nxt_low_overflow_flag; // Next low overflow flag.
  reg [7:0] nxt_reload_low_byte; // Next low reload byte.
  reg [7:0] nxt_reload_high_byte; // Next high reload byte.
  reg [2:0] nxt_irq_status; // Next interrupt status.

  // Oscillator capture synchroniser.
  reg lfo_s1_ff; // First stage, read only by the second.
  reg lfo_s2_ff; // Second stage.
  reg lfo_s3_ff; // Delayed copy for falling edge detection.

  // Decoded strobes.
  // A write to an address that is not decoded here is dropped without effect.
  wire wr_ctrl = i_wr & (i_addr == `DMRT_ADDR_CTRL);
  wire wr_rll = i_wr & (i_addr == `DMRT_ADDR_RLL);
  wire wr_rlh = i_wr & (i_addr == `DMRT_ADDR_RLH);
  wire wr_cntl = i_wr & (i_addr == `DMRT_ADDR_CNTL);
  wire wr_cnth = i_wr & (i_addr == `DMRT_ADDR_CNTH);
  wire wr_cksel = i_wr & (i_addr == `DMRT_ADDR_CKSEL);
  wire wr_ists = i_wr & (i_addr == `DMRT_ADDR_ISTS);
  wire wr_imsk = i_wr & (i_addr == `DMRT_ADDR_IMSK);

  // Counter datapath.
  // Both byte counters are the same module; only their enables and reload
  // controls differ between the 16-bit mode and the split mode.
  wire sys_tick; // System clock divided by 12.
  wire ext_tick; // External oscillator divided by 8.
  wire tick_low; // Selected enable of the low byte.
  wire tick_high; // Selected enable of the high byte.
  wire inc_low; // Low byte counts this cycle.
  wire inc_high; // High byte counts this cycle.
  wire reload_low; // Low byte reloads on its wrap.
  wire wrap_low; // Low byte wraps this cycle.
  wire wrap_high; // High byte or full counter wraps this cycle.
  wire [7:0] count_low_byte; // Low count.
  wire [7:0] count_high_byte; // High count.
  wire capture_evt; // Capture happens this cycle.

  // Dividers for the two slow count rates.
  // Both dividers run freely from reset, so the first slow tick after a change of
  // source may come early; this costs at most one tick and saves a restart path.
  dmrt_tick_gen #(
    .SYS_DIV(SYS_DIV),
    .EXT_DIV(EXT_DIV)
  ) u_tick (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_ext_osc(i_ext_osc),
    .o_sys_tick(sys_tick),
    .o_ext_tick(ext_tick)
  );

  // Each byte picks its own rate; the external select is shared.
  assign tick_low = sel_tick(low_byte_clock_select_ff, external_clock_select_ff,
                             sys_tick, ext_tick);
  assign tick_high = sel_tick(high_byte_clock_select_ff, external_clock_select_ff,
                              sys_tick, ext_tick);

  // In 16-bit mode the low byte clock drives the pair and run gates it all.
  // In split mode the low byte ignores run and the high byte has its own rate.
  // In 16-bit mode the high byte counts on the low wrap only, so the pair can
  // never be seen with the high byte ahead of a carry from the low byte.
  assign inc_low = split_mode_select_ff ? tick_low : (tick_low & run_control_ff);
  assign inc_high = split_mode_select_ff ? (tick_high & run_control_ff) : wrap_low;

  // In 16-bit mode the low byte reloads only when the whole count wraps.
  assign reload_low = split_mode_select_ff | wrap_high;

  // Low byte counter.
  dmrt_byte_cnt u_low (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_wr(wr_cntl),
    .i_wdata(i_wdata),
    .i_inc(inc_low),
    .i_reload(reload_low),
    .i_rl_val(reload_low_byte_ff),
    .o_count(count_low_byte),
    .o_wrap(wrap_low)
  );

  // High byte counter; it always reloads on its own wrap.
  dmrt_byte_cnt u_high (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_wr(wr_cnth),
    .i_wdata(i_wdata),
    .i_inc(inc_high),
    .i_reload(1'b1),
    .i_rl_val(reload_high_byte_ff),
    .o_count(count_high_byte),
    .o_wrap(wrap_high)
  );

  // Capture on a falling edge of the synchronised oscillator when both enables are set.
  // The copy is the count as it stands before the capturing edge; an increment
  // in that same cycle is not part of the captured value.
  assign capture_evt = ~lfo_s2_ff & lfo_s3_ff & lfo_capture_enable_ff
                       & timer_irq_enable_ff;

  // Oscillator synchroniser; only the second and third stages feed logic.
  // All stages reset low, the idle level of the pin, so that no false falling
  // edge and hence no false capture follows the release of reset.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lfo_s1_ff <= 1'b0;
      lfo_s2_ff <= 1'b0;
      lfo_s3_ff <= 1'b0;
    end else begin
      lfo_s1_ff <= i_lfo;
      lfo_s2_ff <= lfo_s1_ff;
      lfo_s3_ff <= lfo_s2_ff;
    end
  end

  // Overflow flags: a hardware set wins over a software clear in the same cycle.
  // Nothing but a software write of zero ever clears them.
  // A software write of one sets a flag, which lets software exercise its
  // overflow handling without waiting for a real wrap.
  always @* begin
    nxt_high_overflow_flag = high_overflow_flag_ff;
    nxt_low_overflow_flag = low_overflow_flag_ff;
    if (wr_ctrl) begin
      nxt_high_overflow_flag = i_wdata[`DMRT_CTRL_HFLAG];
      nxt_low_overflow_flag = i_wdata[`DMRT_CTRL_LFLAG];
    end
    if (wrap_high) begin
      nxt_high_overflow_flag = 1'b1;
    end
    if (wrap_low) begin
      nxt_low_overflow_flag = 1'b1;
    end
  end

  // Reload bytes: the capture copy wins over a software write in the same cycle,
  // because losing a capture would lose an oscillator period measurement.
  always @* begin
    nxt_reload_low_byte = reload_low_byte_ff;
    nxt_reload_high_byte = reload_high_byte_ff;
    if (wr_rll) begin
      nxt_reload_low_byte = i_wdata;
    end
    if (wr_rlh) begin
      nxt_reload_high_byte = i_wdata;
    end
    if (capture_evt) begin
      nxt_reload_low_byte = count_low_byte;
      nxt_reload_high_byte = count_high_byte;
    end
  end

  // Interrupt events: write one to clear, a new event wins over the clear.
  // The low event is recorded only while its enable is set.
  // The high event and the capture event are recorded whenever they happen,
  // so the mask and the global enable decide whether they reach the interrupt output.
  always @* begin
    nxt_irq_status = irq_status_ff;
    if (wr_ists) begin
      nxt_irq_status = irq_status_ff & ~i_wdata[2:0];
    end
    if (wrap_high) begin
      nxt_irq_status[`DMRT_INT_HOVF] = 1'b1;
    end
    if (wrap_low & low_byte_irq_enable_ff) begin
      nxt_irq_status[`DMRT_INT_LOVF] = 1'b1;
    end
    if (capture_evt) begin
      nxt_irq_status[`DMRT_INT_CAP] = 1'b1;
    end
  end

  // Interrupt needs the global enable and an unmasked pending event.
  // It is built from flip-flops only, so bus decode glitches never reach the pin.
  assign o_irq = timer_irq_enable_ff & (|(irq_status_ff & irq_mask_ff));

  // Control, configuration and interrupt registers.
  // Control and clock select fields take their reset values bit by bit from the reset images above, so that no
  // reset assignment narrows a wider constant.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      high_overflow_flag_ff <= CTRL_RST[`DMRT_CTRL_HFLAG];
      low_overflow_flag_ff <= CTRL_RST[`DMRT_CTRL_LFLAG];
      low_byte_irq_enable_ff <= CTRL_RST[`DMRT_CTRL_LBEN];
      lfo_capture_enable_ff <= CTRL_RST[`DMRT_CTRL_CAPEN];
      split_mode_select_ff <= CTRL_RST[`DMRT_CTRL_SPLIT];
      run_control_ff <= CTRL_RST[`DMRT_CTRL_RUN];
      external_clock_select_ff <= CTRL_RST[`DMRT_CTRL_XCLK];
      reload_low_byte_ff <= `DMRT_RL_RST;
      reload_high_byte_ff <= `DMRT_RL_RST;
      low_byte_clock_select_ff <= CKSEL_RST[`DMRT_CKSEL_LSEL];
      high_byte_clock_select_ff <= CKSEL_RST[`DMRT_CKSEL_HSEL];
      timer_irq_enable_ff <= CKSEL_RST[`DMRT_CKSEL_GIE];
      irq_status_ff <= `DMRT_INT_RST;
      irq_mask_ff <= `DMRT_INT_RST;
    end else begin
      high_overflow_flag_ff <= nxt_high_overflow_flag;
      low_overflow_flag_ff <= nxt_low_overflow_flag;
      reload_low_byte_ff <= nxt_reload_low_byte;
      reload_high_byte_ff <= nxt_reload_high_byte;
      irq_status_ff <= nxt_irq_status;
      if (wr_ctrl) begin
        low_byte_irq_enable_ff <= i_wdata[`DMRT_CTRL_LBEN];
        lfo_capture_enable_ff <= i_wdata[`DMRT_CTRL_CAPEN];
        split_mode_select_ff <= i_wdata[`DMRT_CTRL_SPLIT];
        run_control_ff <= i_wdata[`DMRT_CTRL_RUN];
        external_clock_select_ff <= i_wdata[`DMRT_CTRL_XCLK];
      end
      if (wr_cksel) begin
        low_byte_clock_select_ff <= i_wdata[`DMRT_CKSEL_LSEL];
        high_byte_clock_select_ff <= i_wdata[`DMRT_CKSEL_HSEL];
        timer_irq_enable_ff <= i_wdata[`DMRT_CKSEL_GIE];
      end
      if (wr_imsk) begin
        irq_mask_ff <= i_wdata[2:0];
      end
    end
  end

  // Read data is registered and stands for the one cycle after the strobe.
  // Unused bits and unmapped addresses read as zero.
  // Returning zero outside the answer cycle keeps a shared read bus quiet, at
  // the cost of the data being gone one cycle after the answer.
  // Counts are read one byte at a time, so a running 16-bit count may carry
  // between the two reads; software that needs a consistent pair stops the timer.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `DMRT_ADDR_CTRL: begin
          o_rdata <= {high_overflow_flag_ff, low_overflow_flag_ff,
                      low_byte_irq_enable_ff, lfo_capture_enable_ff,
                      split_mode_select_ff, run_control_ff, 1'b0,
                      external_clock_select_ff};
        end
        `DMRT_ADDR_RLL: begin
          o_rdata <= reload_low_byte_ff;
        end
        `DMRT_ADDR_RLH: begin
          o_rdata <= reload_high_byte_ff;
        end
        `DMRT_ADDR_CNTL: begin
          o_rdata <= count_low_byte;
        end
        `DMRT_ADDR_CNTH: begin
          o_rdata <= count_high_byte;
        end
        `DMRT_ADDR_CKSEL: begin
          o_rdata <= {5'h00, timer_irq_enable_ff, high_byte_clock_select_ff,
                      low_byte_clock_select_ff};
        end
        `DMRT_ADDR_ISTS: begin
          o_rdata <= {5'h00, irq_status_ff};
        end
        `DMRT_ADDR_IMSK: begin
          o_rdata <= {5'h00, irq_mask_ff};
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

// ---- dmrt_timer_props.sv ----
// Checker for the reload timer register port and interrupt output.
`timescale 1ns/100ps
`include "dmrt_consts.vh"
module dmrt_timer_props (
  input wire i_clock, // System clock.
  input wire i_arst_n, // Asynchronous reset, active low.
  input wire [7:0] i_addr, // Register address.
  input wire [7:0] i_wdata, // Write data.
  input wire i_wr, // Write strobe.
  input wire i_rd, // Read strobe.
  input wire [7:0] o_rdata, // Read data.
  input wire i_ext_osc, // External oscillator pin.
  input wire i_lfo, // Low-frequency oscillator pin.
  input wire o_irq // Interrupt request.
);
  reg gie_ff; // Shadow of the global interrupt enable.
  reg [2:0] msk_ff; // Shadow of the interrupt mask.
  // The checker cannot see inside, so it tracks the enables from write traffic.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gie_ff <= 1'b0;
      msk_ff <= 3'h0;
    end else if (i_wr && i_addr == `DMRT_ADDR_CKSEL) begin
      gie_ff <= i_wdata[`DMRT_CKSEL_GIE];
    end else if (i_wr && i_addr == `DMRT_ADDR_IMSK) begin
      msk_ff <= i_wdata[2:0];
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_ctrl_bit_one: assert property (i_rd && i_addr == `DMRT_ADDR_CTRL |=> !o_rdata[1])
    else $error("unused control bit reads one");
  a_unmapped_zero: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == 8'h00)
    else $error("unmapped address reads nonzero");
  a_ctrl_readback: assert property (i_wr && i_addr == `DMRT_ADDR_CTRL ##1 !i_wr
    ##1 i_rd && i_addr == `DMRT_ADDR_CTRL |=> (o_rdata & 8'h3D) == ($past(i_wdata, 3) & 8'h3D))
    else $error("control fields do not read back");
  a_reload_readback: assert property (i_wr && i_addr == `DMRT_ADDR_RLL ##1 !i_wr
    ##1 i_rd && i_addr == `DMRT_ADDR_RLL |=> o_rdata == $past(i_wdata, 3))
    else $error("low reload byte does not read back");
  a_gie_off_quiet: assert property (!gie_ff |-> !o_irq)
    else $error("interrupt while globally disabled");
  a_mask_off_quiet: assert property (msk_ff == 3'h0 |-> !o_irq)
    else $error("interrupt while fully masked");
  a_irq_held: assert property ($fell(o_irq) |-> $past(i_wr))
    else $error("interrupt dropped without a write");
endmodule
bind dmrt_timer dmrt_timer_props chk_u (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_ext_osc(i_ext_osc), .i_lfo(i_lfo), .o_irq(o_irq));

// ---- tb_dual_mode_reload_timer.sv ----
// Testbench for the dual-mode reload timer through its register port.
`timescale 1ns/100ps
`include "dmrt_consts.vh"
module tb_dual_mode_reload_timer;
  reg i_clock, i_arst_n, i_wr, i_rd, i_ext_osc, i_lfo; // Design inputs.
  reg [7:0] i_addr, i_wdata; // Register port address and data.
  wire [7:0] o_rdata; // Read data.
  wire o_irq; // Interrupt request.
  integer n_fail, compares, i; // Counters and loop index.
  reg [7:0] v, b; // Read results.
  reg [71:0] amap; // Every mapped address plus one unmapped one.
  // Small dividers keep the rate checks short: sys/3 and ext/2.
  dmrt_timer #(.SYS_DIV(4'h3), .EXT_DIV(4'h2)) dut_u (.i_clock(i_clock),
    .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ext_osc(i_ext_osc), .i_lfo(i_lfo), .o_irq(o_irq));
  // System clock, 40 ns period.
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // External oscillator, one rising edge every six system clocks.
  initial begin
    i_ext_osc = 1'b0;
    forever begin
      repeat (3) @(posedge i_clock);
      i_ext_osc <= ~i_ext_osc;
    end
  end
  // Prints the verdict and ends the run.
  task final_report;
    begin
      if (n_fail == 0 && compares > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  // Compares one value and reports a mismatch.
  task chk(input [7:0] seen, input [7:0] exp, input [63:0] what);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // One write cycle.
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
    end
  endtask
  // One read cycle; the data are taken in the answer cycle only.
  task rdv(input [7:0] a, output [7:0] d);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      @(negedge i_clock);
      d = o_rdata;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input [63:0] what);
    begin
      rdv(a, v);
      chk(v, exp, what);
    end
  endtask
  task irq(input e);
    begin
      @(negedge i_clock);
      chk({7'h00, o_irq}, {7'h00, e}, "irq");
    end
  endtask
  // Polls a register until a bit shows, with a bound.
  task poll(input [7:0] a, input [7:0] m);
    integer k;
    begin
      v = 8'h00;
      for (k = 0; k < 300 && (v & m) === 8'h00; k = k + 1) rdv(a, v);
      if ((v & m) !== m) begin
        chk(v & m, m, "poll");
        final_report;
      end
    end
  endtask
  // Counts low-byte increments over a fixed span to tell the clock sources apart.
  task rate(input [7:0] ctl, input [7:0] lo, input [7:0] hi);
    begin
      wr(`DMRT_ADDR_CTRL, ctl);
      rdv(`DMRT_ADDR_CNTL, b);
      repeat (48) @(posedge i_clock);
      rdv(`DMRT_ADDR_CNTL, v);
      v = v - b;
      chk({7'h00, v >= lo && v <= hi}, 8'h01, "rate");
    end
  endtask
  // A hang counts as a failure.
  initial begin
    repeat (90000) @(posedge i_clock);
    n_fail = n_fail + 1;
    final_report;
  end
  initial begin
    n_fail = 0;
    compares = 0;
    i_arst_n = 1'b0;
    {i_wr, i_rd, i_lfo, i_addr, i_wdata} = 19'h00000;
    amap = {8'h00, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0, 8'hD1, 8'hD2};
    repeat (8) @(posedge i_clock);
    i_arst_n <= 1'b1;
    for (i = 0; i < 9; i = i + 1) rd(amap[i*8 +: 8], 8'h00, "reset");
    wr(`DMRT_ADDR_CTRL, 8'h2F);
    rd(`DMRT_ADDR_CTRL, 8'h2D, "ctrl");
    wr(`DMRT_ADDR_RLL, 8'hA7);
    rd(`DMRT_ADDR_RLL, 8'hA7, "rll");
    // Full 16-bit wrap reloads both bytes and sets both flags.
    wr(`DMRT_ADDR_CTRL, 8'h00);
    wr(`DMRT_ADDR_RLL, 8'h34);
    wr(`DMRT_ADDR_RLH, 8'h12);
    wr(`DMRT_ADDR_CNTL, 8'hF0);
    wr(`DMRT_ADDR_CNTH, 8'hFF);
    wr(`DMRT_ADDR_CKSEL, 8'h01);
    wr(`DMRT_ADDR_CTRL, 8'h24);
    poll(`DMRT_ADDR_CTRL, 8'h80);
    chk(v, 8'hE4, "flags");
    wr(`DMRT_ADDR_CTRL, 8'hE0);
    rdv(`DMRT_ADDR_CNTL, v);
    chk({7'h00, v >= 8'h34 && v <= 8'h3F}, 8'h01, "cntl");
    rd(`DMRT_ADDR_CTRL, 8'hE0, "flags");
    rd(`DMRT_ADDR_CNTH, 8'h12, "cnth");
    rd(`DMRT_ADDR_ISTS, 8'h03, "ists");
    // Interrupt needs mask and global enable; status clears by writing ones.
    wr(`DMRT_ADDR_IMSK, 8'h03);
    irq(1'b0);
    wr(`DMRT_ADDR_CKSEL, 8'h05);
    irq(1'b1);
    wr(`DMRT_ADDR_ISTS, 8'h01);
    irq(1'b1);
    wr(`DMRT_ADDR_IMSK, 8'h01);
    irq(1'b0);
    wr(`DMRT_ADDR_ISTS, 8'h02);
    rd(`DMRT_ADDR_ISTS, 8'h00, "ists");
    rd(`DMRT_ADDR_CTRL, 8'hE0, "sticky");
    wr(`DMRT_ADDR_CTRL, 8'h00);
    rd(`DMRT_ADDR_CTRL, 8'h00, "ctrl");
    // Split mode: low byte runs with run bit off, low interrupt disabled.
    wr(`DMRT_ADDR_IMSK, 8'h07);
    wr(`DMRT_ADDR_RLL, 8'hFE);
    wr(`DMRT_ADDR_CNTL, 8'hFE);
    wr(`DMRT_ADDR_CNTH, 8'h77);
    wr(`DMRT_ADDR_CTRL, 8'h08);
    poll(`DMRT_ADDR_CTRL, 8'h40);
    rd(`DMRT_ADDR_CNTH, 8'h77, "hold");
    rd(`DMRT_ADDR_ISTS, 8'h00, "ists");
    irq(1'b0);
    // Split high byte reloads from its own byte.
    wr(`DMRT_ADDR_RLH, 8'h55);
    wr(`DMRT_ADDR_CNTH, 8'hFE);
    wr(`DMRT_ADDR_CKSEL, 8'h06);
    wr(`DMRT_ADDR_CTRL, 8'h0C);
    poll(`DMRT_ADDR_CTRL, 8'h80);
    wr(`DMRT_ADDR_CTRL, 8'h08);
    rdv(`DMRT_ADDR_CNTH, v);
    chk({7'h00, v >= 8'h55 && v <= 8'h70}, 8'h01, "hreload");
    repeat (20) @(posedge i_clock);
    irq(1'b1);
    // Low byte rate: external/2 versus system/3.
    wr(`DMRT_ADDR_RLL, 8'h00);
    rate(8'h09, 8'h03, 8'h06);
    rate(8'h08, 8'h10, 8'h12);
    // Capture copies the stopped count on a falling edge.
    wr(`DMRT_ADDR_ISTS, 8'h07);
    wr(`DMRT_ADDR_IMSK, 8'h04);
    wr(`DMRT_ADDR_CTRL, 8'h10);
    wr(`DMRT_ADDR_CNTL, 8'h5A);
    wr(`DMRT_ADDR_CNTH, 8'hA5);
    i_lfo <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_lfo <= 1'b0;
    repeat (8) @(posedge i_clock);
    rd(`DMRT_ADDR_RLL, 8'h5A, "caplo");
    rd(`DMRT_ADDR_RLH, 8'hA5, "caphi");
    rd(`DMRT_ADDR_ISTS, 8'h04, "capst");
    irq(1'b1);
    final_report;
  end
endmodule
